// *** bench/sdp_bus_master.sv ***
`timescale 1ns/10ps
`default_nettype none

// Bus master on one port: pins {addr, data, rw, oe_n, cs_n, cs, ub_n, lb_n, lat, ld_n, adv_n, clr_n}
module sdp_bus_master (
	// Pins towards the port
	output logic [41:0] pins_out
);
	initial pins_out = 42'h000000003B7;

	// Called just after a clock edge; hands back the pins really driven
	task automatic put(input logic [41:0] v, output logic [41:0] w);
		w = v;
		w[9] = v[9] | ~v[2]; // Never write while taking an external address
		// A released data bus must not keep showing the last written word
		if (w[9]) begin
			w[27:10] = ~pins_out[27:10];
		end
		pins_out <= w;
	endtask
endmodule

`default_nettype wire

// *** bench/sdp_dual_port_ram_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none

module sdp_ram_checker (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// Port A pins
	input wire logic port_a_read_write_in,
	input wire logic port_a_output_enable_n_in,
	input wire logic port_a_chip_select_low_active_n_in,
	input wire logic port_a_chip_select_high_active_in,
	input wire logic port_a_upper_lane_select_n_in,
	input wire logic port_a_lower_lane_select_n_in,
	input wire logic port_a_output_latency_select_in,
	input wire logic [1:0] port_a_data_oe_n_out,
	input wire logic port_a_standby_out
);
	logic sel, rd, oe, pipe, flow, last_lat;
	logic [1:0] lanes, oen;
	logic [2:0] lat_age;
	assign sel = !port_a_chip_select_low_active_n_in && port_a_chip_select_high_active_in;
	assign rd = port_a_read_write_in;
	assign oe = port_a_output_enable_n_in;
	assign lanes = {port_a_upper_lane_select_n_in, port_a_lower_lane_select_n_in};
	assign oen = port_a_data_oe_n_out;
	// Mode is trusted only once the strap has settled past the filter
	assign pipe = port_a_output_latency_select_in && lat_age == 3'h7;
	assign flow = !port_a_output_latency_select_in && lat_age == 3'h7;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			lat_age <= 3'h0;
			last_lat <= 1'b0;
		end else begin
			last_lat <= port_a_output_latency_select_in;
			if (last_lat != port_a_output_latency_select_in) begin
				lat_age <= 3'h0;
			end else if (lat_age != 3'h7) begin
				lat_age <= lat_age + 3'h1;
			end
		end
	end

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n_in);

	a_deselect_standby: assert property (!sel |=> port_a_standby_out)
		else $error("standby not raised after deselect");
	a_select_active: assert property (sel |=> !port_a_standby_out)
		else $error("standby raised while selected");
	a_oe_floats: assert property (oe |-> oen == 2'h3)
		else $error("lane driven with output enable high");
	a_flow_deselect: assert property (flow && !sel |=> oen == 2'h3)
		else $error("flow deselect did not float in one cycle");
	a_pipe_deselect: assert property (pipe && !sel ##1 !sel |=> oen == 2'h3)
		else $error("pipelined deselect did not float in two cycles");
	a_pipe_late_drive: assert property (pipe && sel && rd && lanes == 2'h0 ##1
		(!sel && lanes == 2'h0) ##1 !oe |-> oen == 2'h0)
		else $error("pipelined read lost after quick deselect");
	a_pipe_read_late: assert property (pipe && !sel ##1 (sel && rd) |=> oen == 2'h3)
		else $error("pipelined read drove one cycle early");
	a_flow_lanes: assert property (flow && sel && rd ##1 !oe |-> oen == $past(lanes))
		else $error("flow read lanes wrong");
	a_pipe_lanes: assert property (pipe && sel && rd ##2 !oe |-> oen == $past(lanes))
		else $error("pipelined read lanes not from latest edge");
	a_write_quiet: assert property (flow && sel && !rd |=> oen == 2'h3)
		else $error("write cycle drove data");

	cover property (pipe && sel && rd);
	cover property (flow && sel && !rd);
	cover property (flow && sel && rd ##1 oe);
endmodule

bind sdp_dual_port_ram sdp_ram_checker i_sdp_ram_checker (.*);

`default_nettype wire

// *** bench/sdp_dual_port_ram_tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module sdp_dual_port_ram_tb;
	import sdp_pkg::*;
	logic clk_sys_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [41:0] pin_a, pin_b;
	logic [41:0] pv [2];
	logic [41:0] v [2];
	logic [1:0][17:0] dout;
	logic [1:0][1:0] oen;
	logic [1:0] sb;
	logic [17:0] mem [SDP_WORDS];
	logic [13:0] ra [2];
	logic [18:0] e1 [2];
	logic [18:0] e2 [2];
	int n_mismatch = 0;
	int tests_run = 0;
	int cyc = 0;
	int seed = 41986;

	always #2.5 clk_sys_in = ~clk_sys_in;

	sdp_bus_master i_sdp_bus_master_a (.pins_out(pin_a));
	sdp_bus_master i_sdp_bus_master_b (.pins_out(pin_b));
	sdp_dual_port_ram i_sdp_dual_port_ram (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.port_a_address_in(pin_a[41:28]),
		.port_a_data_in(pin_a[27:10]),
		.port_a_data_out(dout[0]),
		.port_a_data_oe_n_out(oen[0]),
		.port_a_read_write_in(pin_a[9]),
		.port_a_output_enable_n_in(pin_a[8]),
		.port_a_chip_select_low_active_n_in(pin_a[7]),
		.port_a_chip_select_high_active_in(pin_a[6]),
		.port_a_upper_lane_select_n_in(pin_a[5]),
		.port_a_lower_lane_select_n_in(pin_a[4]),
		.port_a_output_latency_select_in(pin_a[3]),
		.port_a_address_load_strobe_n_in(pin_a[2]),
		.port_a_counter_advance_enable_n_in(pin_a[1]),
		.port_a_counter_clear_n_in(pin_a[0]),
		.port_a_standby_out(sb[0]),
		.port_b_address_in(pin_b[41:28]),
		.port_b_data_in(pin_b[27:10]),
		.port_b_data_out(dout[1]),
		.port_b_data_oe_n_out(oen[1]),
		.port_b_read_write_in(pin_b[9]),
		.port_b_output_enable_n_in(pin_b[8]),
		.port_b_chip_select_low_active_n_in(pin_b[7]),
		.port_b_chip_select_high_active_in(pin_b[6]),
		.port_b_upper_lane_select_n_in(pin_b[5]),
		.port_b_lower_lane_select_n_in(pin_b[4]),
		.port_b_output_latency_select_in(pin_b[3]),
		.port_b_address_load_strobe_n_in(pin_b[2]),
		.port_b_counter_advance_enable_n_in(pin_b[1]),
		.port_b_counter_clear_n_in(pin_b[0]),
		.port_b_standby_out(sb[1])
	);

	function automatic logic [13:0] nxt(input logic [13:0] a, input logic [41:0] w);
		if (!w[0]) return 14'h0000;
		if (!w[2]) return w[41:28];
		if (!w[1]) return a + 14'h0001;
		return a;
	endfunction

	function automatic logic on(input logic [41:0] w);
		return !w[7] && w[6];
	endfunction

	// Addresses cluster at both ends of the array so reads hit written words and wrap
	function automatic logic [41:0] rnd(input logic lat);
		logic [41:0] w;
		w = 42'({$random(seed), $random(seed)});
		w[41:28] = (w[41:28] & 14'h000F) | (w[40] ? 14'h3FF0 : 14'h0000);
		w[0] = w[0] | w[11] | w[12];
		w[3] = lat;
		w[8] = w[8] & w[13];
		w[7] = w[7] & w[14];
		w[6] = w[6] | w[15];
		return w;
	endfunction

	function automatic logic [41:0] mk(input logic [13:0] ad, input logic [17:0] d,
		input logic [3:0] k);
		return {ad, d, k[3], 6'h04, k[2:0]};
	endfunction

	task automatic chk(input string what, input logic [17:0] seen, input logic [17:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic step(input logic [41:0] a, input logic [41:0] b);
		logic drv;
		logic [1:0] lx;
		@(posedge clk_sys_in);
		#1;
		for (int p = 0; p < 2; p++) begin
			drv = pv[p][3] ? e2[p][18] : e1[p][18];
			chk("standby", 18'(sb[p]), 18'(!on(pv[p])));
			lx = ~(~pv[p][5:4] & {2{drv && !pv[p][8]}});
			chk("lanes", {16'h0000, oen[p]}, {16'h0000, lx});
			if (drv) chk("data", dout[p], pv[p][3] ? e2[p][17:0] : e1[p][17:0]);
		end
		i_sdp_bus_master_a.put(a, v[0]);
		i_sdp_bus_master_b.put(b, v[1]);
		// Output enable must act at once, without waiting for a clock edge
		#1;
		for (int p = 0; p < 2; p++) begin
			drv = pv[p][3] ? e2[p][18] : e1[p][18];
			lx = ~(~pv[p][5:4] & {2{drv && !v[p][8]}});
			chk("lanes_oe", {16'h0000, oen[p]}, {16'h0000, lx});
		end
		for (int p = 0; p < 2; p++) begin
			ra[p] = nxt(ra[p], v[p]);
			e2[p] = e1[p];
			e1[p] = {on(v[p]) && v[p][9], mem[ra[p]]};
		end
		// Port b last, so it wins a same-word collision
		for (int p = 0; p < 2; p++) begin
			if (on(v[p]) && !v[p][9] && !v[p][5]) mem[ra[p]][17:9] = v[p][27:19];
			if (on(v[p]) && !v[p][9] && !v[p][4]) mem[ra[p]][8:0] = v[p][18:10];
			pv[p] = v[p];
		end
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc > 3000) begin
			n_mismatch++;
			test_done();
		end
	end

	initial begin
		for (int p = 0; p < 2; p++) begin
			pv[p] = 42'h000000003B7;
			ra[p] = SDP_ADDR_RESET;
			e1[p] = 19'h00000;
			e2[p] = 19'h00000;
		end
		repeat (16) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		// Write cycles at both ends of the array; cs stays low in them, so no word is written
		for (int i = 0; i < 33; i++) begin
			step(mk(14'h0000, 18'($random(seed)), i == 0 ? 4'h6 : 4'h5),
				mk(14'h3FE0, 18'($random(seed)), i == 0 ? 4'hB : (i == 1 ? 4'h7 : 4'h5)));
		end
		step(mk(14'h0000, 18'h2AAAA, 4'h6), mk(14'h0000, 18'h15555, 4'h6));
		step(mk(14'h3FFF, 18'h00000, 4'hB), 42'h000000003B7);
		step(mk(14'h0000, 18'h00000, 4'hD), mk(14'h0000, 18'h00000, 4'hD));
		step(mk(14'h1234, 18'h00000, 4'hF), 42'h000000003B7);
		for (int i = 0; i < 400; i++) step(rnd(1'b0), rnd(1'b0));
		// The strap changes only while both ports are idle and drained
		for (int i = 0; i < 10; i++) step(42'h000000003B7 | (42'(i > 1) << 3), 42'h000000003B7);
		for (int i = 0; i < 400; i++) step(rnd(1'b1), rnd(1'b0));
		step(42'h000000003BF, 42'h000000003B7);
		test_done();
	end
endmodule

`default_nettype wire

// *** design/sdp_dual_port_ram.sv ***
`timescale 1ns/10ps
`default_nettype none

//
// Behaviour
// - 16K words of 18 bits, 14-bit address.
// - Both ports reach any word concurrently.
// - Pipelined mode delays read data one cycle.
// - Lane selects pass one register stage.
// - Chip selects: standby one stage; drive one stage flow, two pipelined.
// - Deselect floats outputs, port enters standby.
// - Selected only with low-active low, high-active high.
// - Write upper bits when upper lane low.
// - Write lower bits when lower lane low.
// - Read drives only lanes whose select low.
// - Output enable high floats both lanes asynchronously.
// - Load high, clear high, advance low increments.
// - Load, advance, clear high: address held.
// - Clear low forces internal address zero.
// - Counter works regardless of selects.
// - Synchronous inputs registered on rising edge.
// - Load low, clear high takes external address.
module sdp_dual_port_ram (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// Port A address and data
	input wire logic [sdp_pkg::SDP_ADDR_W-1:0] port_a_address_in,
	input wire logic [sdp_pkg::SDP_DATA_W-1:0] port_a_data_in,
	output logic [sdp_pkg::SDP_DATA_W-1:0] port_a_data_out,
	output logic [1:0] port_a_data_oe_n_out,
	// Port A control
	input wire logic port_a_read_write_in,
	input wire logic port_a_output_enable_n_in,
	input wire logic port_a_chip_select_low_active_n_in,
	input wire logic port_a_chip_select_high_active_in,
	input wire logic port_a_upper_lane_select_n_in,
	input wire logic port_a_lower_lane_select_n_in,
	input wire logic port_a_output_latency_select_in,
	// Port A address counter
	input wire logic port_a_address_load_strobe_n_in,
	input wire logic port_a_counter_advance_enable_n_in,
	input wire logic port_a_counter_clear_n_in,
	// Port A status
	output logic port_a_standby_out,
	// Port B address and data
	input wire logic [sdp_pkg::SDP_ADDR_W-1:0] port_b_address_in,
	input wire logic [sdp_pkg::SDP_DATA_W-1:0] port_b_data_in,
	output logic [sdp_pkg::SDP_DATA_W-1:0] port_b_data_out,
	output logic [1:0] port_b_data_oe_n_out,
	// Port B control
	input wire logic port_b_read_write_in,
	input wire logic port_b_output_enable_n_in,
	input wire logic port_b_chip_select_low_active_n_in,
	input wire logic port_b_chip_select_high_active_in,
	input wire logic port_b_upper_lane_select_n_in,
	input wire logic port_b_lower_lane_select_n_in,
	input wire logic port_b_output_latency_select_in,
	// Port B address counter
	input wire logic port_b_address_load_strobe_n_in,
	input wire logic port_b_counter_advance_enable_n_in,
	input wire logic port_b_counter_clear_n_in,
	// Port B status
	output logic port_b_standby_out
);
	import sdp_pkg::*;

	// Storage array, shared by both ports; no reset, like any RAM
	logic [SDP_DATA_W-1:0] mem [0:SDP_WORDS-1];

	// All control state of both ports
	typedef struct packed {
		sdp_port_state_t [SDP_PORTS-1:0] port;
	} sdp_top_state_t;

	sdp_top_state_t st;
	sdp_top_state_t next_st;

	// Per-port views of the pins, so both ports share one description
	logic [SDP_ADDR_W-1:0] pin_addr [SDP_PORTS];
	logic [SDP_DATA_W-1:0] pin_data [SDP_PORTS];
	logic pin_rw [SDP_PORTS];
	logic pin_oe_n [SDP_PORTS];
	logic pin_cs_low_n [SDP_PORTS];
	logic pin_cs_high [SDP_PORTS];
	logic pin_upper_n [SDP_PORTS];
	logic pin_lower_n [SDP_PORTS];
	logic pin_load_n [SDP_PORTS];
	logic pin_advance_n [SDP_PORTS];
	logic pin_clear_n [SDP_PORTS];
	logic pin_latency [SDP_PORTS];
	logic latency_mode [SDP_PORTS];

	// Write strobes of the current edge
	logic write_upper [SDP_PORTS];
	logic write_lower [SDP_PORTS];
	logic [SDP_DATA_W-1:0] out_data [SDP_PORTS];
	logic [1:0] out_oe_n [SDP_PORTS];
	logic out_standby [SDP_PORTS];

	assign pin_addr[0] = port_a_address_in;
	assign pin_data[0] = port_a_data_in;
	assign pin_rw[0] = port_a_read_write_in;
	assign pin_oe_n[0] = port_a_output_enable_n_in;
	assign pin_cs_low_n[0] = port_a_chip_select_low_active_n_in;
	assign pin_cs_high[0] = port_a_chip_select_high_active_in;
	assign pin_upper_n[0] = port_a_upper_lane_select_n_in;
	assign pin_lower_n[0] = port_a_lower_lane_select_n_in;
	assign pin_load_n[0] = port_a_address_load_strobe_n_in;
	assign pin_advance_n[0] = port_a_counter_advance_enable_n_in;
	assign pin_clear_n[0] = port_a_counter_clear_n_in;
	assign pin_latency[0] = port_a_output_latency_select_in;

	assign pin_addr[1] = port_b_address_in;
	assign pin_data[1] = port_b_data_in;
	assign pin_rw[1] = port_b_read_write_in;
	assign pin_oe_n[1] = port_b_output_enable_n_in;
	assign pin_cs_low_n[1] = port_b_chip_select_low_active_n_in;
	assign pin_cs_high[1] = port_b_chip_select_high_active_in;
	assign pin_upper_n[1] = port_b_upper_lane_select_n_in;
	assign pin_lower_n[1] = port_b_lower_lane_select_n_in;
	assign pin_load_n[1] = port_b_address_load_strobe_n_in;
	assign pin_advance_n[1] = port_b_counter_advance_enable_n_in;
	assign pin_clear_n[1] = port_b_counter_clear_n_in;
	assign pin_latency[1] = port_b_output_latency_select_in;

	// The latency pin is a static strap from outside the clock domain
	sdp_level_filter u_latency_a (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.level_in(pin_latency[0]),
		.level_out(latency_mode[0])
	);

	sdp_level_filter u_latency_b (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.level_in(pin_latency[1]),
		.level_out(latency_mode[1])
	);

	always_comb begin
		logic selected;
		logic read_now;
		logic [SDP_ADDR_W-1:0] used_addr;
		sdp_addr_src_t src;
		selected = 1'b0;
		read_now = 1'b0;
		used_addr = SDP_ADDR_RESET;
		src = SDP_SRC_HOLD;
		next_st = st;
		for (int p = 0; p < SDP_PORTS; p++) begin
			// Both enables must agree, so depth expansion needs no decoder
			selected = !pin_cs_low_n[p] && pin_cs_high[p];
			// Counter control ignores chip and lane selects
			if (!pin_clear_n[p]) begin
				src = SDP_SRC_CLEAR;
			end else if (!pin_load_n[p]) begin
				src = SDP_SRC_EXTERNAL;
			end else if (!pin_advance_n[p]) begin
				src = SDP_SRC_ADVANCE;
			end else begin
				src = SDP_SRC_HOLD;
			end
			case (src)
				SDP_SRC_CLEAR: begin
					used_addr = SDP_ADDR_RESET;
				end
				SDP_SRC_EXTERNAL: begin
					used_addr = pin_addr[p];
				end
				SDP_SRC_ADVANCE: begin
					// Natural 14-bit overflow wraps the top word back to zero
					used_addr = st.port[p].addr + SDP_ADDR_STEP;
				end
				default: begin
					used_addr = st.port[p].addr;
				end
			endcase
			next_st.port[p].addr = used_addr;

			// Writes happen only on a selected cycle with direction low
			write_upper[p] = selected && !pin_rw[p] && !pin_upper_n[p];
			write_lower[p] = selected && !pin_rw[p] && !pin_lower_n[p];

			// Control inputs captured in one register stage
			read_now = selected && pin_rw[p];
			next_st.port[p].selected1 = selected;
			next_st.port[p].upper_n1 = pin_upper_n[p];
			next_st.port[p].lower_n1 = pin_lower_n[p];
			next_st.port[p].rd_en1 = read_now;
			// Deselected ports skip the array read, saving power in standby
			if (read_now) begin
				next_st.port[p].rd_stage = mem[used_addr];
			end

			if (latency_mode[p] == SDP_LATENCY_PIPE) begin
				// Second stage: data and chip select one cycle later
				next_st.port[p].dout = st.port[p].rd_stage;
				next_st.port[p].drive = st.port[p].rd_en1;
			end else begin
				// Flow-through: data and chip select from this edge
				if (read_now) begin
					next_st.port[p].dout = mem[used_addr];
				end
				next_st.port[p].drive = read_now;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int p = 0; p < SDP_PORTS; p++) begin
				st.port[p].addr <= SDP_ADDR_RESET;
				st.port[p].rd_stage <= SDP_DATA_RESET;
				st.port[p].dout <= SDP_DATA_RESET;
				st.port[p].rd_en1 <= 1'b0;
				st.port[p].drive <= 1'b0;
				st.port[p].upper_n1 <= 1'b1;
				st.port[p].lower_n1 <= 1'b1;
				st.port[p].selected1 <= 1'b0;
			end
		end else begin
			st <= next_st;
		end
	end

	// Port B is written after port A, so B wins a same-word collision
	always_ff @(posedge clk_sys_in) begin
		for (int p = 0; p < SDP_PORTS; p++) begin
			if (write_upper[p]) begin
				mem[next_st.port[p].addr][SDP_UPPER_MSB:SDP_UPPER_LSB] <=
					pin_data[p][SDP_UPPER_MSB:SDP_UPPER_LSB];
			end
			if (write_lower[p]) begin
				mem[next_st.port[p].addr][SDP_LOWER_MSB:SDP_LOWER_LSB] <=
					pin_data[p][SDP_LOWER_MSB:SDP_LOWER_LSB];
			end
		end
	end

	// Output enable acts without the clock; lanes use the single-stage selects
	always_comb begin
		for (int p = 0; p < SDP_PORTS; p++) begin
			out_data[p] = st.port[p].dout;
			out_oe_n[p][SDP_OE_UPPER] = !(st.port[p].drive && !st.port[p].upper_n1
				&& !pin_oe_n[p]);
			out_oe_n[p][SDP_OE_LOWER] = !(st.port[p].drive && !st.port[p].lower_n1
				&& !pin_oe_n[p]);
			out_standby[p] = !st.port[p].selected1;
		end
	end

	assign port_a_data_out = out_data[0];
	assign port_a_data_oe_n_out = out_oe_n[0];
	assign port_a_standby_out = out_standby[0];
	assign port_b_data_out = out_data[1];
	assign port_b_data_oe_n_out = out_oe_n[1];
	assign port_b_standby_out = out_standby[1];

endmodule

`default_nettype wire

// *** design/sdp_level_filter.sv ***
`timescale 1ns/10ps
`default_nettype none

// Three-stage synchroniser for a level from outside the clock domain.
// A change counts only once the second and third stages agree.
module sdp_level_filter (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// Level
	input wire logic level_in,
	output logic level_out
);
	import sdp_pkg::*;

	sdp_filter_state_t st;
	sdp_filter_state_t next_st;

	always_comb begin
		next_st = st;
		next_st.shift = {st.shift[1:0], level_in};
		// Stage 0 is read only by stage 1
		if (st.shift[1] == st.shift[2]) begin
			next_st.level = st.shift[2];
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st <= {3'h0, SDP_LATENCY_RESET};
		end else begin
			st <= next_st;
		end
	end

	assign level_out = st.level;

endmodule

`default_nettype wire

// *** design/sdp_pkg.sv ***
package sdp_pkg;

	// Array geometry
	localparam int SDP_ADDR_W = 14;
	localparam int SDP_DATA_W = 18;
	localparam int SDP_LANE_W = 9;
	localparam int SDP_WORDS = 16384;
	localparam int SDP_PORTS = 2;

	// Lane field positions inside a data word
	localparam int SDP_LOWER_LSB = 0;
	localparam int SDP_LOWER_MSB = 8;
	localparam int SDP_UPPER_LSB = 9;
	localparam int SDP_UPPER_MSB = 17;

	// Index of each lane in the per-port output enable pair
	localparam int SDP_OE_LOWER = 0;
	localparam int SDP_OE_UPPER = 1;

	// Reset values and counter step
	localparam logic [SDP_ADDR_W-1:0] SDP_ADDR_RESET = 14'h0000;
	localparam logic [SDP_ADDR_W-1:0] SDP_ADDR_STEP = 14'h0001;
	localparam logic [SDP_DATA_W-1:0] SDP_DATA_RESET = 18'h00000;

	// Latency select encoding and its value after reset
	localparam logic SDP_LATENCY_FLOW = 1'h0;
	localparam logic SDP_LATENCY_PIPE = 1'h1;
	localparam logic SDP_LATENCY_RESET = SDP_LATENCY_FLOW;

	// Internal address source chosen at a clock edge
	typedef enum logic [1:0] {
		SDP_SRC_CLEAR = 2'b00,
		SDP_SRC_EXTERNAL = 2'b01,
		SDP_SRC_ADVANCE = 2'b10,
		SDP_SRC_HOLD = 2'b11
	} sdp_addr_src_t;

	// Registered state of one port
	typedef struct packed {
		logic [SDP_ADDR_W-1:0] addr;
		logic [SDP_DATA_W-1:0] rd_stage;
		logic [SDP_DATA_W-1:0] dout;
		logic rd_en1;
		logic drive;
		logic upper_n1;
		logic lower_n1;
		logic selected1;
	} sdp_port_state_t;

	// State of the pin filter
	typedef struct packed {
		logic [2:0] shift;
		logic level;
	} sdp_filter_state_t;

endpackage
